// file: rtl/drive_comm_defs.vh
// Register offsets, field positions and reset values of the drive communication map.
// Contract
// - Trip word bits 0-6: overcurrent, overvoltage, external A, base block, low volt, no motor, ground.
// - Trip word bit 7 overheat, bit 8 motor thermal, bit 9 overload trip.
// - Trip word bit 10 hardware diagnostic fault, bit 11 broken pipe.
// - Trip bit 12 second overcurrent, 13 level limit, 14 phase open, 15 drive overload.
// - Status bit 10 local mode, bit 11 forward command, bit 12 reverse command.
// - Status bit 13 remote run/stop source, bit 14 remote frequency source.
// - Input status mirrors eight inputs in bits 0-7; bits 8-15 reserved zero.
// - Output status mirrors four aux outputs bits 0-3, bits 4-6 zero, relay bit 7.
// - Command bit 0 rising from 0 to 1 issues a stop.
// - Command bit 1 rising starts forward run, bit 2 rising starts reverse run.
// - Command bit 3 rising clears the latched fault.
// - Command bit 4 rising issues emergency stop; bit 5 is unused.
// - Command bits 6-7 read the run source: terminal, keypad, option, serial.
// - Writes are accepted only after write-enable location was set to 1; the write-enable location itself accepts writes at any time.
`ifndef DRIVE_COMM_DEFS_VH
`define DRIVE_COMM_DEFS_VH
`define ADDR_WRITE_EN      8'h04
`define ADDR_RUN_CMD       8'h06
`define ADDR_OP_STATUS     8'h0e
`define ADDR_TRIP_FLAGS    8'h0f
`define ADDR_INPUT_PINS    8'h10
`define ADDR_OUTPUT_PINS   8'h11
`define ADDR_VOLT_ONE      8'h12
`define ADDR_VOLT_TWO      8'h13
`define ADDR_CURR_IN       8'h14
`define ADDR_RPM           8'h15
`define ADDR_UNIT_SEL      8'h1a
`define ADDR_POLES         8'h1b
`define ADDR_CUSTOM_VER    8'h1c
`define ADDR_PID_SET       8'h1d
`define ADDR_PID_FB        8'h1e
`define CMD_STOP_BIT       0
`define CMD_FWD_BIT        1
`define CMD_REV_BIT        2
`define CMD_RESET_BIT      3
`define CMD_ESTOP_BIT      4
`define CMD_SRC_LSB        6
`define CMD_WRITE_MASK     16'h001f
`define STAT_LOCAL_BIT     10
`define STAT_REM_RS_BIT    13
`define STAT_REMOTE_FREQUENCY_FLAG_BIT  14
`define SRC_SERIAL         2'h3
`define SRC_OPTION         2'h2
`define RESET_ZERO16       16'h0000
`endif

// file: rtl/cmd_edge_detect.v
// Rising-edge detector for the writable command bits.
`timescale 1ns/1ps
module cmd_edge_detect #(
    parameter WIDTH = 5
) (
    input  wire             clk,
    input  wire             rst,
    input  wire             ce,
    input  wire [WIDTH-1:0] level,
    output wire [WIDTH-1:0] rise
);
    reg [WIDTH-1:0] prev_ff;
    // Remembers the last command value so only a 0 to 1 change fires.
    always @(posedge clk) begin
        if (rst) begin
            prev_ff <= {WIDTH{1'b0}};
        end else if (ce) begin
            prev_ff <= level;
        end
    end
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_edge
            assign rise[g] = level[g] & ~prev_ff[g];
        end
    endgenerate
endmodule

// file: rtl/status_word_pack.v
// Packs live drive signals into the status, terminal and trip words.
`timescale 1ns/1ps
`include "drive_comm_defs.vh"
module status_word_pack (
    input  wire [9:0]  op_low,
    input  wire        local_mode,
    input  wire        fwd_active,
    input  wire        rev_active,
    input  wire [1:0]  run_src,
    input  wire        freq_remote,
    input  wire [15:0] trip_in,
    input  wire [7:0]  mf_inputs,
    input  wire [3:0]  aux_outputs,
    input  wire        fault_relay,
    output wire [15:0] op_word,
    output wire [15:0] trip_word,
    output wire [15:0] in_word,
    output wire [15:0] out_word
);
    // Run/stop is remote when it comes from the option card or the serial link.
    wire rem_rs = (run_src == `SRC_SERIAL) | (run_src == `SRC_OPTION);
    assign op_word = {1'b0, freq_remote, rem_rs, rev_active, fwd_active, local_mode,
                      op_low};
    // Trip causes arrive already in the documented bit order.
    assign trip_word = trip_in;
    assign in_word = {8'h00, mf_inputs};
    assign out_word = {8'h00, fault_relay, 3'h0, aux_outputs};
endmodule

// file: rtl/drive_comm_regs.v
// Communication register map of the drive: status readback and command word.
`timescale 1ns/1ps
`include "drive_comm_defs.vh"
module drive_comm_regs (
    input  wire        CORE_CLK,
    input  wire        SRST,
    input  wire        CE,
    input  wire        WR_STB,
    input  wire        RD_STB,
    input  wire [7:0]  ADDR,
    input  wire [15:0] WDATA,
    input  wire [9:0]  OP_STATUS_LOW,
    input  wire        LOCAL_MODE,
    input  wire        FWD_ACTIVE,
    input  wire        REV_ACTIVE,
    input  wire [1:0]  RUN_SOURCE,
    input  wire        FREQ_REMOTE,
    input  wire [15:0] TRIP_CAUSES,
    input  wire [7:0]  MF_INPUTS,
    input  wire [3:0]  AUX_OUTPUTS,
    input  wire        FAULT_RELAY,
    input  wire [15:0] VOLT_ONE_RAW,
    input  wire [15:0] VOLT_TWO_RAW,
    input  wire [15:0] CURR_IN_RAW,
    input  wire [15:0] MOTOR_RPM,
    input  wire [15:0] UNIT_SELECT,
    input  wire [15:0] POLE_COUNT,
    input  wire [15:0] CUSTOM_VERSION,
    input  wire [15:0] PID_SETPOINT,
    input  wire [15:0] PID_FEEDBACK,
    output reg  [15:0] RDATA,
    output reg         RVALID,
    output reg         STOP_PULSE,
    output reg         FWD_RUN_PULSE,
    output reg         REV_RUN_PULSE,
    output reg         FAULT_RESET_PULSE,
    output reg         ESTOP_PULSE,
    output reg         WRITE_ENABLED
);
    reg  [4:0]  cmd_ff;
    reg  [4:0]  nxt_cmd;
    reg         wen_ff;
    reg  [15:0] nxt_rdata;
    wire [4:0]  cmd_rise;
    wire [15:0] op_word;
    wire [15:0] trip_word;
    wire [15:0] in_word;
    wire [15:0] out_word;
    wire        wr_ok;
    wire [15:0] cmd_wdata;

    status_word_pack u_pack (
        .op_low      (OP_STATUS_LOW),
        .local_mode  (LOCAL_MODE),
        .fwd_active  (FWD_ACTIVE),
        .rev_active  (REV_ACTIVE),
        .run_src     (RUN_SOURCE),
        .freq_remote (FREQ_REMOTE),
        .trip_in     (TRIP_CAUSES),
        .mf_inputs   (MF_INPUTS),
        .aux_outputs (AUX_OUTPUTS),
        .fault_relay (FAULT_RELAY),
        .op_word     (op_word),
        .trip_word   (trip_word),
        .in_word     (in_word),
        .out_word    (out_word)
    );

    cmd_edge_detect #(.WIDTH(5)) u_edge (
        .clk   (CORE_CLK),
        .rst   (SRST),
        .ce    (CE),
        .level (cmd_ff),
        .rise  (cmd_rise)
    );

    // A write lands only once the master has armed the write-enable location.
    assign wr_ok = WR_STB & wen_ff;

    // Only the five action bits are writable; the source field is never stored.
    assign cmd_wdata = WDATA & `CMD_WRITE_MASK;
    always @* begin
        nxt_cmd = cmd_ff;
        if (wr_ok && ADDR == `ADDR_RUN_CMD) begin
            nxt_cmd = cmd_wdata[4:0];
        end
    end

    // Read multiplexer; unmapped addresses read zero, read-only write targets simply read their sources.
    always @* begin
        case (ADDR)
            `ADDR_WRITE_EN:    nxt_rdata = {15'h0000, wen_ff};
            `ADDR_RUN_CMD:     nxt_rdata = {8'h00, RUN_SOURCE, 1'b0, cmd_ff};
            `ADDR_OP_STATUS:   nxt_rdata = op_word;
            `ADDR_TRIP_FLAGS:  nxt_rdata = trip_word;
            `ADDR_INPUT_PINS:  nxt_rdata = in_word;
            `ADDR_OUTPUT_PINS: nxt_rdata = out_word;
            `ADDR_VOLT_ONE:    nxt_rdata = VOLT_ONE_RAW;
            `ADDR_VOLT_TWO:    nxt_rdata = VOLT_TWO_RAW;
            `ADDR_CURR_IN:     nxt_rdata = CURR_IN_RAW;
            `ADDR_RPM:         nxt_rdata = MOTOR_RPM;
            `ADDR_UNIT_SEL:    nxt_rdata = UNIT_SELECT;
            `ADDR_POLES:       nxt_rdata = POLE_COUNT;
            `ADDR_CUSTOM_VER:  nxt_rdata = CUSTOM_VERSION;
            `ADDR_PID_SET:     nxt_rdata = PID_SETPOINT;
            `ADDR_PID_FB:      nxt_rdata = PID_FEEDBACK;
            default:           nxt_rdata = `RESET_ZERO16;
        endcase
    end

    // Register state, read answer and one-cycle command pulses.
    always @(posedge CORE_CLK) begin
        if (SRST) begin
            cmd_ff            <= 5'h00;
            wen_ff            <= 1'b0;
            RDATA             <= `RESET_ZERO16;
            RVALID            <= 1'b0;
            STOP_PULSE        <= 1'b0;
            FWD_RUN_PULSE     <= 1'b0;
            REV_RUN_PULSE     <= 1'b0;
            FAULT_RESET_PULSE <= 1'b0;
            ESTOP_PULSE       <= 1'b0;
            WRITE_ENABLED     <= 1'b0;
        end else if (CE) begin
            cmd_ff <= nxt_cmd;
            // Writing 1 arms writes; writing 0 disarms. This location is always writable.
            if (WR_STB && ADDR == `ADDR_WRITE_EN) begin
                wen_ff <= WDATA[0];
            end
            WRITE_ENABLED     <= wen_ff;
            RVALID            <= RD_STB;
            if (RD_STB) begin
                RDATA <= nxt_rdata;
            end
            STOP_PULSE        <= cmd_rise[`CMD_STOP_BIT];
            FWD_RUN_PULSE     <= cmd_rise[`CMD_FWD_BIT];
            REV_RUN_PULSE     <= cmd_rise[`CMD_REV_BIT];
            FAULT_RESET_PULSE <= cmd_rise[`CMD_RESET_BIT];
            ESTOP_PULSE       <= cmd_rise[`CMD_ESTOP_BIT];
        end
    end
endmodule

// file: verif/link_master.sv
// Register bus master model standing in for the serial link side.
`timescale 1ns/1ps
module link_master (
    input  wire        CORE_CLK,
    output reg         WR_STB,
    output reg         RD_STB,
    output reg  [7:0]  ADDR,
    output reg  [15:0] WDATA
);
    // The bus is idle at time zero.
    initial {WR_STB, RD_STB, ADDR, WDATA} = 26'h0;
    // One strobed cycle; the released bus then shows inverted values.
    task xfer(input w, input [7:0] a, input [15:0] d);
        @(negedge CORE_CLK);
        {WR_STB, RD_STB, ADDR, WDATA} = {w, !w, a, d};
        @(negedge CORE_CLK);
        {WR_STB, RD_STB, ADDR, WDATA} = {2'b00, ~a, ~d};
    endtask
endmodule

// file: verif/drive_comm_regs_checker.sv
// Assertions on the ports of the drive command map.
`timescale 1ns/1ps
module drive_comm_regs_checker (
    input wire        CORE_CLK,
    input wire        SRST,
    input wire        CE,
    input wire        WR_STB,
    input wire        RD_STB,
    input wire [7:0]  ADDR,
    input wire [15:0] WDATA,
    input wire [1:0]  RUN_SOURCE,
    input wire [15:0] TRIP_CAUSES,
    input wire [7:0]  MF_INPUTS,
    input wire [15:0] RDATA,
    input wire        RVALID,
    input wire        STOP_PULSE,
    input wire        FWD_RUN_PULSE,
    input wire        REV_RUN_PULSE,
    input wire        FAULT_RESET_PULSE,
    input wire        ESTOP_PULSE,
    input wire        WRITE_ENABLED
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SRST);
    // Decoded command writes and reads.
    wire cw = CE && WR_STB && ADDR == 8'h06;
    wire rq = CE && RD_STB;
    AST_TRIP: assert property (rq && ADDR == 8'h0f |=> RDATA == $past(TRIP_CAUSES))
        else $error("trip word mismatch");
    AST_INP: assert property (rq && ADDR == 8'h10 |=> RDATA == {8'h00, $past(MF_INPUTS)})
        else $error("input word mismatch");
    AST_SRC: assert property (rq && ADDR == 8'h06 |=> RDATA[7:5] == {$past(RUN_SOURCE), 1'b0})
        else $error("run source mismatch");
    AST_WEN: assert property ($rose(WRITE_ENABLED) |-> $past(CE && WR_STB && ADDR == 8'h04, 2))
        else $error("write enable rose alone");
    AST_LOCK: assert property (cw && WDATA[0] ##1 !WRITE_ENABLED |=> !STOP_PULSE)
        else $error("locked write acted");
    AST_STOP: assert property (STOP_PULSE |-> $past(cw && WDATA[0], 2))
        else $error("stop without command");
    AST_FWD: assert property (FWD_RUN_PULSE |-> $past(cw && WDATA[1], 2) ##1 !FWD_RUN_PULSE)
        else $error("bad forward pulse");
    AST_ESTOP: assert property (ESTOP_PULSE |-> $past(cw && WDATA[4], 2))
        else $error("estop without command");
    AST_REV: assert property (REV_RUN_PULSE |-> $past(cw && WDATA[2], 2))
        else $error("reverse without command");
    AST_FRST: assert property (FAULT_RESET_PULSE |-> $past(cw && WDATA[3], 2))
        else $error("fault reset without command");
    AST_RVALID: assert property (rq |=> RVALID)
        else $error("read answer missing");
endmodule
bind drive_comm_regs drive_comm_regs_checker i_drive_comm_regs_checker (.*);

// file: verif/drive_comm_status_command_map_test.sv
// Self-checking bench for the drive command map.
`timescale 1ns/1ps
module drive_comm_status_command_map_test;
    reg CORE_CLK, SRST, CE, LOCAL_MODE, FWD_ACTIVE, REV_ACTIVE, FREQ_REMOTE, FAULT_RELAY;
    reg [1:0] RUN_SOURCE;
    reg [3:0] AUX_OUTPUTS;
    reg [7:0] MF_INPUTS, a;
    reg [9:0] OP_STATUS_LOW;
    reg [15:0] VOLT_ONE_RAW, VOLT_TWO_RAW, CURR_IN_RAW, MOTOR_RPM, UNIT_SELECT, POLE_COUNT;
    reg [15:0] CUSTOM_VERSION, PID_SETPOINT, PID_FEEDBACK, TRIP_CAUSES, rq[$], pq[$];
    reg wen_exp;
    reg [4:0] cmd_exp;
    wire WR_STB, RD_STB, RVALID, STOP_PULSE, FWD_RUN_PULSE, REV_RUN_PULSE;
    wire FAULT_RESET_PULSE, ESTOP_PULSE, WRITE_ENABLED;
    wire [7:0] ADDR;
    wire [15:0] WDATA, RDATA;
    integer n_fail = 0, num_checks = 0, cyc = 0, i;
    drive_comm_regs i_drive_comm_regs (.*);
    link_master i_link_master (.*);
    task chk(input [39:0] nm, input [15:0] e, input [15:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
        end
    endtask
    task end_sim;
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Expected read value of an address from the current live inputs.
    function [15:0] ex(input [7:0] ad);
        case (ad)
            8'h04: ex = {15'h0000, wen_exp};
            8'h06: ex = {8'h00, RUN_SOURCE, 1'b0, cmd_exp};
            8'h0e: ex = {1'b0, FREQ_REMOTE, RUN_SOURCE[1], REV_ACTIVE, FWD_ACTIVE,
                         LOCAL_MODE, OP_STATUS_LOW};
            8'h0f: ex = TRIP_CAUSES;
            8'h10: ex = {8'h00, MF_INPUTS};
            8'h11: ex = {8'h00, FAULT_RELAY, 3'h0, AUX_OUTPUTS};
            8'h12: ex = VOLT_ONE_RAW;
            8'h13: ex = VOLT_TWO_RAW;
            8'h14: ex = CURR_IN_RAW;
            8'h15: ex = MOTOR_RPM;
            8'h1a: ex = UNIT_SELECT;
            8'h1b: ex = POLE_COUNT;
            8'h1c: ex = CUSTOM_VERSION;
            8'h1d: ex = PID_SETPOINT;
            8'h1e: ex = PID_FEEDBACK;
            default: ex = 16'h0000;
        endcase
    endfunction
    task wr(input [7:0] ad, input [15:0] d);
        if (CE && ad == 8'h04) wen_exp = d[0];
        if (CE && wen_exp && ad == 8'h06) cmd_exp = d[4:0];
        i_link_master.xfer(1'b1, ad, d);
    endtask
    task rd(input [7:0] ad);
        rq.push_back(ex(ad));
        i_link_master.xfer(1'b0, ad, 16'h0000);
    endtask
    // Clock of 40 ns period.
    initial begin
        CORE_CLK = 0;
        forever #20 CORE_CLK = ~CORE_CLK;
    end
    // Main sequence.
    initial begin
        {SRST, CE} = 2'b11;
        {OP_STATUS_LOW, LOCAL_MODE, FWD_ACTIVE, REV_ACTIVE, RUN_SOURCE, FREQ_REMOTE} = 0;
        {MF_INPUTS, AUX_OUTPUTS, FAULT_RELAY, VOLT_ONE_RAW, VOLT_TWO_RAW, CURR_IN_RAW} = 0;
        {MOTOR_RPM, UNIT_SELECT, POLE_COUNT, CUSTOM_VERSION} = 0;
        {PID_SETPOINT, PID_FEEDBACK, TRIP_CAUSES} = 0;
        wen_exp = 1'b0;
        cmd_exp = 5'h00;
        void'($urandom(32'h62918707));
        repeat (20) @(posedge CORE_CLK);
        @(negedge CORE_CLK) SRST = 0;
        wr(8'h06, 16'h0001);
        rd(8'h06);
        wr(8'h04, 16'h0001);
        rd(8'h04);
        for (i = 0; i < 5; i++) begin
            pq.push_back(16'h0001 << i);
            repeat (2) wr(8'h06, 16'h0001 << i);
            rd(8'h06);
            wr(8'h06, 16'h0000);
        end
        // A command written while the clock enable is low must leave no trace.
        CE = 0;
        wr(8'h06, 16'h0001);
        CE = 1;
        wr(8'h06, 16'hffe0);
        rd(8'h06);
        repeat (4) begin
            {OP_STATUS_LOW, LOCAL_MODE, FWD_ACTIVE, REV_ACTIVE, RUN_SOURCE, FREQ_REMOTE,
             MF_INPUTS, AUX_OUTPUTS, FAULT_RELAY} = $urandom;
            {VOLT_ONE_RAW, VOLT_TWO_RAW, CURR_IN_RAW, MOTOR_RPM, UNIT_SELECT, POLE_COUNT,
             CUSTOM_VERSION, PID_SETPOINT, PID_FEEDBACK,
             TRIP_CAUSES} = {$urandom, $urandom, $urandom, $urandom, $urandom};
            for (a = 8'h0e; a <= 8'h20; a++) wr(a, $urandom);
            rd(8'h06);
            for (a = 8'h0e; a <= 8'h20; a++) rd(a);
        end
        wr(8'h04, 16'h0000);
        rd(8'h04);
        wr(8'h06, 16'h0001);
        repeat (5) @(posedge CORE_CLK);
        chk("left", 16'h0000, rq.size() + pq.size());
        end_sim;
    end
    // Result watcher: each read or pulse takes the oldest note.
    always @(posedge CORE_CLK) begin
        #1;
        if (RVALID === 1'b1) chk("rdata", rq.pop_front(), RDATA);
        if ({ESTOP_PULSE, FAULT_RESET_PULSE, REV_RUN_PULSE, FWD_RUN_PULSE, STOP_PULSE} !== 5'h0)
            chk("pulse", pq.pop_front(), {11'h0, ESTOP_PULSE, FAULT_RESET_PULSE,
                REV_RUN_PULSE, FWD_RUN_PULSE, STOP_PULSE});
    end
    // Cycle ceiling against a hang.
    always @(posedge CORE_CLK) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            end_sim;
        end
    end
endmodule
